// ---- adc_seq_pkg.sv ----
package adc_seq_pkg;
   // register addresses on the internal register port
   localparam logic [7:0] ADDR_CHANNEL_SELECT    = 8'h99;
   localparam logic [7:0] ADDR_CONVERTER_CONFIG  = 8'h9A;
   localparam logic [7:0] ADDR_CONVERTER_CONTROL = 8'h9B;
   localparam logic [7:0] ADDR_RESULT_BASE       = 8'hA0; // result low bytes
   localparam logic [7:0] ADDR_RESULT_HI_BASE    = 8'hA8; // result high bits
   // field positions
   localparam int CFG_ENABLE_BIT  = 7;
   localparam int CFG_CLK_LSB     = 0;
   localparam int CTL_START_BIT   = 0;
   localparam int CTL_LOOP_BIT    = 1;
   localparam int CTL_AVG_LSB     = 2;
   localparam int CTL_FLAG_BIT    = 7;
   // reset values
   localparam logic [7:0] CHANNEL_SELECT_RESET    = 8'h00;
   localparam logic [7:0] CONVERTER_CONFIG_RESET  = 8'h00;
   localparam logic [7:0] CONVERTER_CONTROL_RESET = 8'h00;
   // geometry
   localparam int NUM_CHANNELS = 5;
   localparam int RESULT_BITS  = 10;
   localparam int CH_BITS      = 3;
   // lockout release hold-off
   localparam int CLK_FREQ_HZ     = 100_000_000;
   localparam int HOLDOFF_MS      = 10;
   localparam int HOLDOFF_CYCLES  = CLK_FREQ_HZ / 1000 * HOLDOFF_MS;
   localparam int HOLDOFF_BITS    = 20;
   // sequencer states
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_START,
      ST_WAIT,
      ST_NEXT,
      ST_STORE
   } seq_state_t;
endpackage

// ---- result_if.sv ----
// write and read ports of the result store
interface result_if;
   logic                  wr_en;   // store one averaged result
   logic [2:0]            wr_ch;   // channel being written
   logic [9:0]            wr_data; // averaged result
   logic [2:0]            rd_ch;   // channel being read
   logic [9:0]            rd_data; // registered read data
   modport store (input wr_en, input wr_ch, input wr_data, input rd_ch, output rd_data);
   modport user  (output wr_en, output wr_ch, output wr_data, output rd_ch, input rd_data);
endinterface

// ---- adc_result_mem.sv ----
// one independent result word per channel, registered read
module adc_result_mem
(
   input  wire logic clk_sys,
   input  wire logic sys_rst,
   result_if.store   res
);
   logic [9:0] word [0:4];      // stored results
   logic [9:0] next_word [0:4]; // next stored results
   logic [9:0] next_rd_data;    // next read data

   // one generate loop, each channel touches only its own word
   for (genvar g = 0; g < 5; g++)
   begin : g_ch
      always_comb
      begin
         next_word[g] = word[g];
         if (res.wr_en && res.wr_ch == 3'(g))
         begin
            next_word[g] = res.wr_data; // see R08
         end
      end
      always_ff @(posedge clk_sys)
      begin
         if (sys_rst)
         begin
            word[g] <= 10'h000;
         end
         else
         begin
            word[g] <= next_word[g];
         end
      end
   end

   // read data from a register; out of range reads zero
   always_comb
   begin
      next_rd_data = (res.rd_ch < 3'h5) ? word[res.rd_ch] : 10'h000;
   end
   always_ff @(posedge clk_sys)
   begin
      if (sys_rst)
      begin
         res.rd_data <= 10'h000;
      end
      else
      begin
         res.rd_data <= next_rd_data;
      end
   end
endmodule // adc_result_mem

// ---- adc_channel_sequencer.sv ----
// Operation
// R01 - sequence 10-bit converter over five inputs
// R02 - channels 3, 4 read divided regulator rails
// R03 - converter runs only while enable bit set
// R04 - channel select field chooses scanned inputs
// R05 - start bit begins scan, clears complete flag
// R06 - selected channels converted one after another
// R07 - complete flag set after all results stored
// R08 - each channel result in own register
// R09 - loop bit zero: scan once then stop
// R10 - loop bit one: rescan continuously
// R11 - average several conversions per channel
// R12 - two-bit field picks conversion clock
// R13 - lockout entry restores all register defaults; result words keep their values
// R14 - no register access until 10ms after lockout
// R15 - bit n selects channel n; disabled start ignored
module adc_channel_sequencer
#(
   parameter int HOLDOFF_CYCLES = adc_seq_pkg::HOLDOFF_CYCLES // lockout release hold-off
)
(
   input  wire logic       clk_sys,
   input  wire logic       sys_rst,
   input  wire logic       uvlo,        // supply undervoltage lockout level
   input  wire logic       reg_wr,      // register write strobe
   input  wire logic       reg_rd,      // register read strobe
   input  wire logic [7:0] reg_addr,    // register address
   input  wire logic [7:0] reg_wdata,   // register write data
   output logic      [7:0] reg_rdata,   // registered read data
   output logic            reg_rvalid,  // read data valid pulse
   output logic            regs_ready,  // register access open
   output logic            conv_start,  // pulse to analog core
   output logic      [2:0] conv_mux,    // analog mux channel
   output logic      [1:0] conv_clk_sel,// conversion clock choice
   output logic            conv_enable, // analog core enable
   input  wire logic       conv_done,   // core finished a conversion
   input  wire logic [9:0] conv_data    // core result
);
   // software registers
   logic [7:0] channel_select;
   logic [7:0] converter_config;
   logic [7:0] converter_control;
   logic [7:0] next_channel_select;
   logic [7:0] next_converter_config;
   logic [7:0] next_converter_control;
   // sequencer state
   adc_seq_pkg::seq_state_t state;
   adc_seq_pkg::seq_state_t next_state;
   logic [2:0]  ch;          // current channel
   logic [2:0]  next_ch;
   logic [3:0]  samples;     // conversions done on this channel
   logic [3:0]  next_samples;
   logic [13:0] acc;         // sample accumulator
   logic [13:0] next_acc;
   logic [9:0]  avg_value;   // averaged result
   // lockout handling
   logic        uvlo_q;      // previous lockout level
   logic [19:0] holdoff;     // cycles left before access opens
   logic [19:0] next_holdoff;
   logic        access_ok;
   logic [7:0]  rd_mux;      // read data before register
   logic        start_req;   // accepted start request
   result_if    res ();

   adc_result_mem u_mem
   (
      .clk_sys (clk_sys),
      .sys_rst (sys_rst),
      .res     (res)
   );

   wire logic enabled   = converter_config[adc_seq_pkg::CFG_ENABLE_BIT];
   wire logic loop_mode = converter_control[adc_seq_pkg::CTL_LOOP_BIT];
   wire logic [1:0] avg_sel = converter_control[adc_seq_pkg::CTL_AVG_LSB +: 2];
   wire logic [4:0] sel = channel_select[4:0];
   wire logic [3:0] avg_n = 4'(1) << avg_sel; // 1, 2, 4 or 8 samples
   wire logic lockout_rst = sys_rst || uvlo; // see R13

   // access opens only after the hold-off has run out
   assign access_ok  = (holdoff == 20'h00000) && !uvlo; // see R14
   assign regs_ready = access_ok;

   // a start is honoured only while the converter is enabled
   assign start_req = access_ok && reg_wr && reg_addr == adc_seq_pkg::ADDR_CONVERTER_CONTROL
                      && reg_wdata[adc_seq_pkg::CTL_START_BIT] && enabled; // see R05 see R15

   // next channel above current that is selected, wrapping is not done here
   function automatic logic [3:0] find_next(input logic [4:0] s, input logic [3:0] from);
      logic [3:0] r;
      r = 4'h8;
      for (int i = 4; i >= 0; i--)
      begin
         if (s[i] && 4'(i) >= from)
         begin
            r = 4'(i); // see R15
         end
      end
      return r;
   endfunction

   // hold-off counter, reloaded on lockout and counting after release
   always_comb
   begin
      next_holdoff = holdoff;
      if (uvlo)
      begin
         next_holdoff = 20'(HOLDOFF_CYCLES); // see R14
      end
      else if (holdoff != 20'h00000)
      begin
         next_holdoff = holdoff - 20'h00001;
      end
   end
   always_ff @(posedge clk_sys)
   begin
      if (sys_rst)
      begin
         holdoff <= 20'(HOLDOFF_CYCLES);
         uvlo_q  <= 1'b0;
      end
      else
      begin
         holdoff <= next_holdoff;
         uvlo_q  <= uvlo;
      end
   end

   // register writes; hardware sets the flag, start clears it
   always_comb
   begin
      next_channel_select    = channel_select;
      next_converter_config  = converter_config;
      next_converter_control = converter_control;
      next_converter_control[adc_seq_pkg::CTL_START_BIT] = 1'b0; // start self-clears
      if (access_ok && reg_wr)
      begin
         case (reg_addr)
            adc_seq_pkg::ADDR_CHANNEL_SELECT:
               next_channel_select = {3'b000, reg_wdata[4:0]}; // see R04
            adc_seq_pkg::ADDR_CONVERTER_CONFIG:
               next_converter_config = reg_wdata; // see R03 see R12
            adc_seq_pkg::ADDR_CONVERTER_CONTROL:
            begin
               next_converter_control[6:1] = reg_wdata[6:1]; // loop and averaging
               // a start while disabled is ignored, so it leaves the flag alone
               if (reg_wdata[adc_seq_pkg::CTL_START_BIT] && enabled)
               begin
                  next_converter_control[adc_seq_pkg::CTL_FLAG_BIT] = 1'b0; // see R05 see R15
               end
            end
            default:
               next_converter_control = next_converter_control; // other addresses ignored
         endcase
      end
      // completion set wins over a same-cycle clear
      if (state == adc_seq_pkg::ST_STORE && find_next(sel, 4'(ch) + 4'h1) == 4'h8)
      begin
         next_converter_control[adc_seq_pkg::CTL_FLAG_BIT] = 1'b1; // see R07
      end
   end
   always_ff @(posedge clk_sys)
   begin
      if (lockout_rst)
      begin
         channel_select    <= adc_seq_pkg::CHANNEL_SELECT_RESET;    // see R13
         converter_config  <= adc_seq_pkg::CONVERTER_CONFIG_RESET;
         converter_control <= adc_seq_pkg::CONVERTER_CONTROL_RESET;
      end
      else
      begin
         channel_select    <= next_channel_select;
         converter_config  <= next_converter_config;
         converter_control <= next_converter_control;
      end
   end

   // average: sum of a power-of-two sample count shifted down
   always_comb
   begin
      case (avg_sel)
         2'b00:   avg_value = acc[9:0];
         2'b01:   avg_value = acc[10:1];
         2'b10:   avg_value = acc[11:2];
         default: avg_value = acc[12:3];
      endcase
   end

   // scan sequencer: one channel at a time, averaged, then next
   always_comb
   begin
      next_state   = state;
      next_ch      = ch;
      next_samples = samples;
      next_acc     = acc;
      case (state)
         adc_seq_pkg::ST_IDLE:
         begin
            if (start_req && find_next(sel, 4'h0) != 4'h8)
            begin
               next_ch    = 3'(find_next(sel, 4'h0)); // see R06
               next_state = adc_seq_pkg::ST_START;
            end
         end
         adc_seq_pkg::ST_START:
         begin
            next_state = adc_seq_pkg::ST_WAIT; // start pulse issued here
         end
         adc_seq_pkg::ST_WAIT:
         begin
            if (conv_done)
            begin
               next_acc     = acc + 14'(conv_data); // see R11
               next_samples = samples + 4'h1;
               next_state   = (samples + 4'h1 == avg_n) ? adc_seq_pkg::ST_STORE
                                                        : adc_seq_pkg::ST_START;
            end
         end
         adc_seq_pkg::ST_STORE:
         begin
            next_acc     = 14'h0000;
            next_samples = 4'h0;
            if (find_next(sel, 4'(ch) + 4'h1) != 4'h8)
            begin
               next_ch    = 3'(find_next(sel, 4'(ch) + 4'h1)); // see R06
               next_state = adc_seq_pkg::ST_START;
            end
            else
            begin
               next_state = adc_seq_pkg::ST_NEXT;
            end
         end
         adc_seq_pkg::ST_NEXT:
         begin
            if (loop_mode && find_next(sel, 4'h0) != 4'h8)
            begin
               next_ch    = 3'(find_next(sel, 4'h0)); // see R10
               next_state = adc_seq_pkg::ST_START;
            end
            else
            begin
               next_state = adc_seq_pkg::ST_IDLE; // see R09
            end
         end
         default:
            next_state = adc_seq_pkg::ST_IDLE;
      endcase
      // disabling the converter abandons the scan
      if (!enabled)
      begin
         next_state   = adc_seq_pkg::ST_IDLE; // see R03
         next_samples = 4'h0;
         next_acc     = 14'h0000;
      end
   end
   always_ff @(posedge clk_sys)
   begin
      if (lockout_rst)
      begin
         state   <= adc_seq_pkg::ST_IDLE;
         ch      <= 3'h0;
         samples <= 4'h0;
         acc     <= 14'h0000;
      end
      else
      begin
         state   <= next_state;
         ch      <= next_ch;
         samples <= next_samples;
         acc     <= next_acc;
      end
   end

   // core controls; channel 3/4 are the divided rails inside the core
   assign conv_start   = (state == adc_seq_pkg::ST_START); // see R01 see R02
   assign conv_mux     = ch;
   assign conv_enable  = enabled; // see R03
   assign conv_clk_sel = converter_config[adc_seq_pkg::CFG_CLK_LSB +: 2]; // see R12

   // result store port
   assign res.wr_en   = (state == adc_seq_pkg::ST_STORE); // see R08
   assign res.wr_ch   = ch;
   assign res.wr_data = avg_value;
   assign res.rd_ch   = reg_addr[2:0];

   // read mux; result bytes come from the memory's register a cycle later
   always_comb
   begin
      case (reg_addr)
         adc_seq_pkg::ADDR_CHANNEL_SELECT:    rd_mux = channel_select;
         adc_seq_pkg::ADDR_CONVERTER_CONFIG:  rd_mux = converter_config;
         adc_seq_pkg::ADDR_CONVERTER_CONTROL: rd_mux = converter_control;
         default:                             rd_mux = 8'h00;
      endcase
   end

   logic       rd_q;     // read issued last cycle
   logic [7:0] rd_addr_q;
   logic [7:0] rd_reg_q; // config byte latched with the read
   always_ff @(posedge clk_sys)
   begin
      if (sys_rst)
      begin
         rd_q      <= 1'b0;
         rd_addr_q <= 8'h00;
         rd_reg_q  <= 8'h00;
      end
      else
      begin
         rd_q      <= reg_rd && access_ok; // see R14
         rd_addr_q <= reg_addr;
         rd_reg_q  <= rd_mux;
      end
   end
   // second cycle: pick config byte or result byte, then register
   logic [7:0] next_reg_rdata;
   always_comb
   begin
      next_reg_rdata = reg_rdata;
      if (rd_q)
      begin
         if (rd_addr_q[7:3] == adc_seq_pkg::ADDR_RESULT_BASE[7:3] && rd_addr_q[2:0] < 3'h5)
            next_reg_rdata = res.rd_data[7:0];
         else if (rd_addr_q[7:3] == adc_seq_pkg::ADDR_RESULT_HI_BASE[7:3] && rd_addr_q[2:0] < 3'h5)
            next_reg_rdata = {6'h00, res.rd_data[9:8]};
         else
            next_reg_rdata = rd_reg_q;
      end
   end
   always_ff @(posedge clk_sys)
   begin
      if (sys_rst)
      begin
         reg_rdata  <= 8'h00;
         reg_rvalid <= 1'b0;
      end
      else
      begin
         reg_rdata  <= next_reg_rdata;
         reg_rvalid <= rd_q;
      end
   end

   // assertions
   a_disabled_idle: assert property (@(posedge clk_sys) disable iff (sys_rst) // see R03
      !enabled |=> state == adc_seq_pkg::ST_IDLE) else $error("scan ran while disabled");
   a_start_clears: assert property (@(posedge clk_sys) disable iff (lockout_rst) // see R05
      start_req && state != adc_seq_pkg::ST_STORE |=> !converter_control[7])
      else $error("start did not clear flag");
   a_select_mask: assert property (@(posedge clk_sys) disable iff (sys_rst) // see R15
      conv_start |-> sel[ch]) else $error("unselected channel converted");
   a_flag_after_store: assert property (@(posedge clk_sys) disable iff (lockout_rst) // see R07
      $rose(converter_control[7]) |-> $past(res.wr_en)) else $error("flag without store");
   a_once_stops: assert property (@(posedge clk_sys) disable iff (lockout_rst) // see R09
      state == adc_seq_pkg::ST_NEXT && !loop_mode |=> state == adc_seq_pkg::ST_IDLE)
      else $error("single scan did not stop");
   a_loop_restarts: assert property (@(posedge clk_sys) disable iff (lockout_rst) // see R10
      state == adc_seq_pkg::ST_NEXT && loop_mode && enabled && sel != 5'h00
      |=> state == adc_seq_pkg::ST_START) else $error("loop did not rescan");
   a_avg_count: assert property (@(posedge clk_sys) disable iff (lockout_rst) // see R11
      res.wr_en |-> samples == avg_n) else $error("wrong sample count");
   a_uvlo_defaults: assert property (@(posedge clk_sys) disable iff (sys_rst) // see R13
      uvlo |=> channel_select == 8'h00 && converter_config == 8'h00)
      else $error("lockout kept settings");
   a_holdoff_closed: assert property (@(posedge clk_sys) disable iff (sys_rst) // see R14
      $fell(uvlo_q) |-> !regs_ready) else $error("access open right after lockout");
   c_single_scan: cover property (@(posedge clk_sys) $rose(converter_control[7]) && !loop_mode);
   c_loop_scan: cover property (@(posedge clk_sys) state == adc_seq_pkg::ST_NEXT && loop_mode);
   c_avg_eight: cover property (@(posedge clk_sys) res.wr_en && avg_sel == 2'b11);
endmodule // adc_channel_sequencer

// ---- adc_channel_sequencer_tb.sv ----
module adc_channel_sequencer_tb;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int HOLD = 2000; // hold-off shortened so the run stays short
   logic        clk_sys;     // 100 MHz system clock
   logic        sys_rst;     // synchronous reset
   logic        uvlo;        // lockout level
   logic        reg_wr;      // write strobe
   logic        reg_rd;      // read strobe
   logic [7:0]  reg_addr;    // register address
   logic [7:0]  reg_wdata;   // write data
   logic [7:0]  reg_rdata;   // read data
   logic        reg_rvalid;  // read answer
   logic        regs_ready;  // access open
   logic        conv_start;  // core start pulse
   logic [2:0]  conv_mux;    // core channel
   logic [1:0]  conv_clk_sel;// core clock choice
   logic        conv_enable; // core enable
   logic        conv_done;   // core finished
   logic [9:0]  conv_data;   // core result
   int          err_total;   // mismatches
   int          checked;     // comparisons
   integer      seed;        // fixed random seed
   logic [2:0]  order[$];    // channels seen at each start
   int          sum[5];      // samples summed per channel
   int          cnt[5];      // samples counted per channel
   logic [9:0]  exp_res[5];  // expected result per channel

   adc_channel_sequencer #(.HOLDOFF_CYCLES(HOLD)) u_adc_channel_sequencer (.clk_sys(clk_sys),
      .sys_rst(sys_rst),
      .uvlo(uvlo), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
      .regs_ready(regs_ready), .conv_start(conv_start), .conv_mux(conv_mux),
      .conv_clk_sel(conv_clk_sel), .conv_enable(conv_enable), .conv_done(conv_done),
      .conv_data(conv_data));

   // free running clock
   initial
   begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end

   // log every conversion start, also ones the responder would miss
   always @(posedge clk_sys)
      if (conv_start === 1'b1)
         order.push_back(conv_mux);

   // stand-in for the analog core: prompt or slow answers, data changes after
   initial
   begin : core
      logic [2:0] ch;
      logic [9:0] v;
      int         d;
      conv_done = 1'b0;
      conv_data = 10'h000;
      forever
      begin
         @(posedge clk_sys);
         if (conv_start === 1'b1 && sys_rst === 1'b0)
         begin
            ch = conv_mux;
            v  = 10'($random(seed));
            d  = (($random(seed) & 7) == 0) ? 12 : 1 + ($random(seed) & 3);
            repeat (d) @(negedge clk_sys);
            conv_done = 1'b1;
            conv_data = v;
            if (ch < 3'h5)
            begin
               sum[ch] += v;
               cnt[ch]++;
            end
            @(negedge clk_sys);
            conv_done = 1'b0;
            conv_data = ~v;
         end
      end
   end

   task automatic check_byte(input logic [7:0] got, input logic [7:0] exp, input string what);
      checked++;
      if (got !== exp)
      begin
         err_total++;
         $display("ERROR t=%0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   task automatic check_bit(input logic got, input logic exp, input string what);
      check_byte({7'h00, got}, {7'h00, exp}, what);
   endtask

   task automatic check_num(input int got, input int exp, input string what);
      checked++;
      if (got != exp)
      begin
         err_total++;
         $display("ERROR t=%0t %s got %0d exp %0d", $time, what, got, exp);
      end
   endtask

   // one write strobe, held for exactly one edge
   task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk_sys);
      reg_wr    = 1'b1;
      reg_addr  = a;
      reg_wdata = d;
      @(negedge clk_sys);
      reg_wr    = 1'b0;
      reg_wdata = ~d;
   endtask

   // one read strobe, answer looked for in a bounded window
   task automatic reg_read(input logic [7:0] a, output logic [7:0] d, output logic ok);
      @(negedge clk_sys);
      reg_rd   = 1'b1;
      reg_addr = a;
      @(negedge clk_sys);
      reg_rd   = 1'b0;
      ok       = 1'b0;
      d        = 8'hXX;
      for (int i = 0; i < 4 && !ok; i++)
      begin
         @(posedge clk_sys);
         #1;
         if (reg_rvalid === 1'b1)
         begin
            ok = 1'b1;
            d  = reg_rdata;
         end
      end
   endtask

   task automatic read_expect(input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] d;
      logic       ok;
      reg_read(a, d, ok);
      check_bit(ok, 1'b1, "read answered");
      check_byte(d, exp, "read value");
   endtask

   // counts edges until access opens, bounded past the hold-off
   task automatic wait_ready(output int n);
      n = 0;
      while (regs_ready !== 1'b1 && n < HOLD + 100)
      begin
         @(posedge clk_sys);
         #1;
         n++;
      end
   endtask

   task automatic read_defaults();
      read_expect(adc_seq_pkg::ADDR_CHANNEL_SELECT, adc_seq_pkg::CHANNEL_SELECT_RESET);
      read_expect(adc_seq_pkg::ADDR_CONVERTER_CONFIG, adc_seq_pkg::CONVERTER_CONFIG_RESET);
      read_expect(adc_seq_pkg::ADDR_CONVERTER_CONTROL, adc_seq_pkg::CONVERTER_CONTROL_RESET);
   endtask

   // expected stored value: power-of-two mean of the summed samples
   function automatic logic [9:0] mean_of(input int s, input logic [1:0] a);
      return 10'(s >> a);
   endfunction

   // one single-pass scan, then counts, order, averages and flag
   task automatic run_scan(input logic [4:0] mask, input logic [1:0] avg);
      logic [7:0] d;
      logic       ok;
      int         i;
      int         total;
      for (int k = 0; k < 5; k++)
      begin
         sum[k] = 0;
         cnt[k] = 0;
      end
      order.delete();
      reg_write(adc_seq_pkg::ADDR_CHANNEL_SELECT, {3'h0, mask});
      reg_write(adc_seq_pkg::ADDR_CONVERTER_CONTROL, {4'h0, avg, 2'b01});
      // only long scans are sure to still be running at this read
      if (avg >= 2'd2)
      begin
         reg_read(adc_seq_pkg::ADDR_CONVERTER_CONTROL, d, ok);
         check_bit(d[7], 1'b0, "flag not cleared by start");
      end
      d = 8'h00;
      for (i = 0; i < 200 && d[7] !== 1'b1; i++)
         reg_read(adc_seq_pkg::ADDR_CONVERTER_CONTROL, d, ok);
      check_bit(d[7], 1'b1, "scan never completed");
      total = 0;
      for (int k = 0; k < 5; k++)
      begin
         check_num(cnt[k], mask[k] ? (1 << avg) : 0, "samples at flag");
         for (int j = 0; mask[k] && j < (1 << avg); j++)
         begin
            if (total < order.size())
               check_byte({5'h0, order[total]}, 8'(k), "channel order");
            total++;
         end
      end
      repeat (40) @(posedge clk_sys);
      check_num(order.size(), total, "conversions after single scan");
      for (int k = 0; k < 5; k++)
      begin
         if (mask[k])
            exp_res[k] = mean_of(sum[k], avg);
         read_expect(adc_seq_pkg::ADDR_RESULT_BASE + 8'(k), exp_res[k][7:0]);
         read_expect(adc_seq_pkg::ADDR_RESULT_HI_BASE + 8'(k), {6'h00, exp_res[k][9:8]});
      end
      read_expect(adc_seq_pkg::ADDR_CONVERTER_CONTROL, {1'b1, 3'h0, avg, 2'b00});
   endtask

   task automatic give_verdict();
      $display("counts: checked %0d errors %0d", checked, err_total);
      if (err_total == 0 && checked > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   // two shortened hold-offs plus scans, with wide margin
   initial
   begin
      #800_000;
      err_total++;
      $display("ERROR t=%0t watchdog expired", $time);
      give_verdict();
   end

   // main sequence
   initial
   begin : main
      logic [7:0] d;
      logic       ok;
      logic [4:0] m;
      int         n;
      seed = 32'h61E0E396;
      err_total = 0;
      checked = 0;
      sys_rst = 1'b1;
      uvlo = 1'b0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      for (int k = 0; k < 5; k++)
         exp_res[k] = 10'h000;
      repeat (4) @(negedge clk_sys);
      sys_rst = 1'b0;
      check_bit(regs_ready, 1'b0, "open during hold-off");
      reg_read(adc_seq_pkg::ADDR_CONVERTER_CONTROL, d, ok);
      check_bit(ok, 1'b0, "access taken during hold-off");
      wait_ready(n);
      read_defaults();
      read_expect(8'h40, 8'h00);
      $display("test reset and hold-off done");
      for (int k = 0; k < 4; k++)
      begin
         reg_write(adc_seq_pkg::ADDR_CONVERTER_CONFIG, 8'h80 | 8'(k));
         check_bit(conv_enable, 1'b1, "enable output");
         check_byte({6'h00, conv_clk_sel}, 8'(k), "clock select output");
         read_expect(adc_seq_pkg::ADDR_CONVERTER_CONFIG, 8'h80 | 8'(k));
      end
      $display("test configuration done");
      reg_write(adc_seq_pkg::ADDR_CONVERTER_CONFIG, 8'h00);
      reg_write(adc_seq_pkg::ADDR_CHANNEL_SELECT, 8'h1F);
      n = order.size();
      reg_write(adc_seq_pkg::ADDR_CONVERTER_CONTROL, 8'h01);
      repeat (20) @(posedge clk_sys);
      check_num(order.size(), n, "start while disabled");
      read_expect(adc_seq_pkg::ADDR_CONVERTER_CONTROL, 8'h00);
      $display("test disabled start done");
      reg_write(adc_seq_pkg::ADDR_CONVERTER_CONFIG, 8'h80 | 8'($random(seed) & 3));
      run_scan(5'h1F, 2'd3);
      run_scan(5'h10, 2'd0);
      run_scan(5'h01, 2'd2);
      for (int k = 0; k < 6; k++)
      begin
         m = 5'($random(seed));
         run_scan((m == 5'h00) ? 5'h08 : m, 2'(k));
      end
      $display("test single scans done");
      reg_write(adc_seq_pkg::ADDR_CHANNEL_SELECT, 8'h05);
      order.delete();
      reg_write(adc_seq_pkg::ADDR_CONVERTER_CONTROL, 8'h03);
      for (n = 0; n < 2000 && order.size() < 6; n++)
         @(posedge clk_sys);
      check_num(order.size() >= 6, 1, "loop mode stopped");
      for (int k = 0; k < 6 && k < order.size(); k++)
         check_byte({5'h0, order[k]}, (k % 2 == 0) ? 8'h00 : 8'h02, "loop order");
      reg_write(adc_seq_pkg::ADDR_CONVERTER_CONFIG, 8'h00);
      reg_write(adc_seq_pkg::ADDR_CONVERTER_CONTROL, 8'h01);
      repeat (20) @(posedge clk_sys);
      n = order.size();
      repeat (60) @(posedge clk_sys);
      check_num(order.size(), n, "scan after disable");
      read_expect(adc_seq_pkg::ADDR_CONVERTER_CONTROL, 8'h80);
      $display("test loop mode done");
      reg_write(adc_seq_pkg::ADDR_CONVERTER_CONFIG, 8'h83);
      reg_write(adc_seq_pkg::ADDR_CHANNEL_SELECT, 8'h1F);
      @(negedge clk_sys);
      uvlo = 1'b1;
      repeat (3) @(negedge clk_sys);
      check_bit(regs_ready, 1'b0, "open during lockout");
      check_bit(conv_enable, 1'b0, "enable kept in lockout");
      uvlo = 1'b0;
      wait_ready(n);
      check_num((n >= HOLD - 3 && n <= HOLD + 3),
                1, "hold-off length");
      read_defaults();
      $display("test lockout done");
      give_verdict();
   end
endmodule // adc_channel_sequencer_tb
